// ==== pkg/pio_map.svh ====
`ifndef PIO_MAP_SVH
`define PIO_MAP_SVH

// Register indexes; byte address is four times the index
`define PIO_IDX_PORT_ONE_DATA 10'h0e1
`define PIO_IDX_PORT_ONE_DIR 10'h0e3
`define PIO_IDX_PORT_THREE_DATA 10'h0e5
`define PIO_IDX_PORT_THREE_DIR 10'h0e7
`define PIO_IDX_PORT_FOUR_DATA 10'h0e8
`define PIO_IDX_PORT_FOUR_DIR 10'h0ea
`define PIO_IDX_PIN_MODE 10'h0f8
`define PIO_IDX_PULLUP_A 10'h0fc
`define PIO_IDX_PULLUP_B 10'h0fd
`define PIO_IDX_DRIVE 10'h0fe

// Implemented bit masks
`define PIO_MASK_PORT_ONE 8'hff
`define PIO_MASK_PORT_THREE 8'hb8
`define PIO_MASK_PORT_FOUR_DIR 8'h20
`define PIO_MASK_PORT_FOUR_IN 8'h04
`define PIO_MASK_PORT_FOUR_OSC 8'hc0
`define PIO_MASK_PIN_MODE 8'h88
`define PIO_MASK_DRIVE 8'h0f

// Field positions
`define PIO_BIT_SSI_CHOICE 3
`define PIO_BIT_PERSONALITY 7
`define PIO_BIT_PU_ONE_LOW 2
`define PIO_BIT_PU_ONE_HIGH 3
`define PIO_BIT_PU_THREE_LOW 4
`define PIO_BIT_PU_THREE_HIGH 5
`define PIO_BIT_PU_FOUR 1

// Reset values
`define PIO_RST_DIR 8'h00
`define PIO_RST_PIN_MODE 8'h00
`define PIO_RST_DRIVE 4'h0
`define PIO_RST_PU_ONE 2'h0
`define PIO_RST_PU_FOUR 1'h0

// Bus responses
`define PIO_RESP_OKAY 2'h0
`define PIO_RESP_SLVERR 2'h2

`endif

// ==== pkg/pio_pkg.sv ====
package pio_pkg;

  typedef logic [7:0] pio_byte_t;
  typedef logic [11:0] pio_addr_t;
  typedef logic [9:0] pio_index_t;
  typedef logic [31:0] pio_word_t;
  typedef logic [1:0] pio_resp_t;

  typedef enum logic
  {
    PIO_SERIAL_CLOCKED,
    PIO_SERIAL_TWO_WIRE
  } pio_personality_t;

endpackage

// ==== pkg/pio_regbus_if.sv ====
`timescale 1ns/1ns
interface pio_regbus_if;
  import pio_pkg::*;

  logic wr_req;
  pio_addr_t wr_addr;
  pio_byte_t wr_data;
  logic wr_lane;
  logic wr_ok;
  logic rd_req;
  pio_addr_t rd_addr;
  pio_byte_t rd_data;
  logic rd_ok;

  modport bus
  (
    output wr_req, wr_addr, wr_data, wr_lane, rd_req, rd_addr,
    input wr_ok, rd_data, rd_ok
  );

  modport regs
  (
    input wr_req, wr_addr, wr_data, wr_lane, rd_req, rd_addr,
    output wr_ok, rd_data, rd_ok
  );
endinterface

// ==== verification/pio_port_properties.sv ====
`timescale 1ns/1ns
module pio_port_checker
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire pio_pkg::pio_word_t s_axi_rdata,
  input wire pio_pkg::pio_byte_t port_one_pin_out,
  input wire pio_pkg::pio_byte_t port_one_pin_oe,
  input wire pio_pkg::pio_byte_t port_one_pullup,
  input wire logic [3:0] port_one_high_drive,
  input wire pio_pkg::pio_byte_t port_three_pin_oe,
  input wire pio_pkg::pio_byte_t port_three_pullup,
  input wire pio_pkg::pio_byte_t port_four_pin_oe,
  input wire pio_pkg::pio_personality_t serial_unit_personality_select,
  input wire logic serial_select_pin_choice
);
  import pio_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  //////////////////////////////////////////////////////////////////////////
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_resp;
    s_wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  property p_rd_resp;
    s_rd_taken |=> !s_axi_rvalid ##1 (s_axi_rvalid && s_axi_rdata[31:8] == 24'h0);
  endproperty
  property p_pu_input;
    (port_one_pullup & port_one_pin_oe) == 8'h00
      && (port_three_pullup & port_three_pin_oe) == 8'h00;
  endproperty
  property p_pu_group;
    port_one_pullup[0] && !port_one_pin_oe[1] |-> port_one_pullup[1];
  endproperty
  property p_out_gated;
    (port_one_pin_out & ~port_one_pin_oe) == 8'h00;
  endproperty
  property p_unimpl;
    ((port_three_pin_oe | port_three_pullup) & 8'h47) == 8'h00;
  endproperty
  property p_four_in;
    (port_four_pin_oe & 8'hc4) == 8'h00;
  endproperty
  property p_reset_state;
    $rose(aresetn) |-> port_one_pin_oe == 8'h00 && port_three_pin_oe == 8'h00
      && port_four_pin_oe == 8'h00 && port_one_high_drive == 4'h0
      && serial_unit_personality_select == PIO_SERIAL_CLOCKED
      && !serial_select_pin_choice;
  endproperty
  property p_pin_lag;
    $changed(port_one_pin_oe) |-> $past(s_axi_bvalid);
  endproperty
  property p_mode_lag;
    $changed(serial_unit_personality_select) |-> $past(s_axi_bvalid);
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("late write answer");
  a_rd_resp: assert property (p_rd_resp) else $error("bad read answer");
  a_pu_input: assert property (p_pu_input) else $error("pull-up on output");
  a_pu_group: assert property (p_pu_group) else $error("pull-up group split");
  a_out_gated: assert property (p_out_gated) else $error("driven in input");
  a_unimpl: assert property (p_unimpl) else $error("missing pin active");
  a_four_in: assert property (p_four_in) else $error("input pin driven");
  a_reset_state: assert property (p_reset_state) else $error("reset state");
  a_pin_lag: assert property (p_pin_lag) else $error("direction moved");
  a_mode_lag: assert property (p_mode_lag) else $error("mode moved");
endmodule

// ==== verification/pio_port_top_tb.sv ====
`timescale 1ns/1ns
`include "pio_map.svh"
module pio_port_top_tb;
  import pio_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, main_osc_in_use;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, serial_select_pin_choice;
  pio_addr_t s_axi_awaddr, s_axi_araddr;
  pio_word_t s_axi_wdata, s_axi_rdata, rv;
  pio_resp_t s_axi_bresp, s_axi_rresp;
  logic [3:0] s_axi_wstrb, port_one_high_drive;
  pio_byte_t port_one_pin_in, port_one_pin_out, port_one_pin_oe;
  pio_byte_t port_three_pin_in, port_three_pin_out, port_three_pin_oe;
  pio_byte_t port_four_pin_in, port_four_pin_out, port_four_pin_oe;
  pio_byte_t port_one_pullup, port_three_pullup, port_four_pullup;
  pio_personality_t serial_unit_personality_select;
  int miscompares = 0;
  int num_checks = 0;
  int cyc = 0;
  pio_index_t rst_idx[5] = '{`PIO_IDX_PORT_ONE_DIR, `PIO_IDX_PORT_THREE_DIR,
    `PIO_IDX_PORT_FOUR_DIR, `PIO_IDX_PIN_MODE, `PIO_IDX_DRIVE};
  pio_byte_t md[4] = '{8'hff, 8'h08, 8'h80, 8'h00};

  pio_port_top uut (.*);

  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      miscompares = miscompares + 1;
      final_report();
    end
  end

  task automatic chk(input pio_word_t got, input pio_word_t exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input pio_index_t i, input pio_byte_t d, input pio_resp_t e);
    logic a;
    logic w;
    @(posedge aclk);
    a = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(a && w))
    begin
      @(posedge aclk);
      a = a | s_axi_awready;
      w = w | s_axi_wready;
      s_axi_awvalid <= !a;
      s_axi_wvalid <= !w;
    end
    do
      @(posedge aclk);
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, e);
  endtask

  task automatic rd(input pio_index_t i, input pio_resp_t e);
    @(posedge aclk);
    s_axi_araddr <= {i, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
      @(posedge aclk);
    while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do
      @(posedge aclk);
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rv = s_axi_rdata;
    chk(s_axi_rresp, e);
  endtask

  task automatic rdc(input pio_index_t i, input pio_word_t exp);
    rd(i, `PIO_RESP_OKAY);
    chk(rv, exp);
  endtask

  task automatic settle();
    repeat (2) @(posedge aclk);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    aresetn = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h1;
    port_one_pin_in = 8'h00;
    port_three_pin_in = 8'hff;
    port_four_pin_in = 8'hdf;
    main_osc_in_use = 1'b1;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(port_one_pin_oe | port_three_pin_oe | port_four_pin_oe, 0);
    foreach (rst_idx[k])
      rdc(rst_idx[k], 32'h0);
    rd(`PIO_IDX_PULLUP_A, `PIO_RESP_OKAY);
    chk(rv & 32'hcf, 32'h0);
    $display("test reset done");
    wr(`PIO_IDX_PORT_ONE_DIR, 8'h0f, `PIO_RESP_OKAY);
    wr(`PIO_IDX_PORT_ONE_DATA, 8'ha5, `PIO_RESP_OKAY);
    wr(`PIO_IDX_PULLUP_A, 8'h04, `PIO_RESP_OKAY);
    port_one_pin_in <= 8'h3c;
    rdc(`PIO_IDX_PORT_ONE_DATA, 32'h35);
    chk(port_one_pin_out, 8'h05);
    chk(port_one_pullup, 8'h00);
    wr(`PIO_IDX_PORT_ONE_DIR, 8'hf0, `PIO_RESP_OKAY);
    settle();
    chk(port_one_pin_out, 8'ha0);
    chk(port_one_pullup, 8'h0f);
    rdc(`PIO_IDX_PORT_ONE_DATA, 32'hac);
    $display("test port one done");
    wr(`PIO_IDX_PORT_THREE_DIR, 8'hff, `PIO_RESP_OKAY);
    rdc(`PIO_IDX_PORT_THREE_DIR, 32'hb8);
    wr(`PIO_IDX_PULLUP_A, 8'h30, `PIO_RESP_OKAY);
    wr(`PIO_IDX_PORT_THREE_DATA, 8'h4f, `PIO_RESP_OKAY);
    settle();
    chk(port_three_pin_oe, 8'hb8);
    chk(port_three_pin_out, 8'h08);
    chk(port_three_pullup, 8'h00);
    wr(`PIO_IDX_PORT_THREE_DIR, 8'h00, `PIO_RESP_OKAY);
    settle();
    chk(port_three_pullup, 8'hb8);
    chk(port_one_pullup, 8'h00);
    rdc(`PIO_IDX_PORT_THREE_DATA, 32'hb8);
    $display("test port three done");
    wr(`PIO_IDX_DRIVE, 8'hff, `PIO_RESP_OKAY);
    rdc(`PIO_IDX_DRIVE, 32'h0f);
    chk(port_one_high_drive, 4'hf);
    wr(`PIO_IDX_PORT_FOUR_DIR, 8'hff, `PIO_RESP_OKAY);
    rdc(`PIO_IDX_PORT_FOUR_DIR, 32'h20);
    chk(port_four_pin_oe, 8'h20);
    wr(`PIO_IDX_PORT_FOUR_DATA, 8'hff, `PIO_RESP_OKAY);
    rdc(`PIO_IDX_PORT_FOUR_DATA, 32'h24);
    main_osc_in_use <= 1'b0;
    rdc(`PIO_IDX_PORT_FOUR_DATA, 32'he4);
    chk(port_four_pin_out, 8'h20);
    wr(`PIO_IDX_PULLUP_B, 8'hff, `PIO_RESP_OKAY);
    rdc(`PIO_IDX_PULLUP_B, 32'h02);
    chk(port_four_pullup, 8'h00);
    wr(`PIO_IDX_PORT_FOUR_DIR, 8'h00, `PIO_RESP_OKAY);
    settle();
    chk(port_four_pullup, 8'h20);
    $display("test port four done");
    for (int k = 0; k < 4; k++)
    begin
      wr(`PIO_IDX_PIN_MODE, md[k], `PIO_RESP_OKAY);
      settle();
      rdc(`PIO_IDX_PIN_MODE, {24'h0, md[k] & 8'h88});
      chk(serial_unit_personality_select, md[k][7]);
      chk(serial_select_pin_choice, md[k][3]);
    end
    $display("test mode done");
    wr(10'h0e2, 8'hff, `PIO_RESP_SLVERR);
    rd(10'h0e9, `PIO_RESP_SLVERR);
    chk(rv, 32'h0);
    s_axi_wstrb <= 4'h0;
    wr(`PIO_IDX_PORT_ONE_DIR, 8'hff, `PIO_RESP_OKAY);
    s_axi_wstrb <= 4'h1;
    rdc(`PIO_IDX_PORT_ONE_DIR, 32'hf0);
    $display("test unmapped done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdc(`PIO_IDX_PORT_ONE_DIR, 32'h0);
    chk(port_one_pin_oe, 8'h00);
    $display("test second reset done");
    final_report();
  end
endmodule

bind pio_port_top pio_port_checker chk_i (.*);

// ==== verilog/pio_axil_slave.sv ====
`timescale 1ns/1ns
`include "pio_map.svh"
module pio_axil_slave
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire pio_pkg::pio_addr_t awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire pio_pkg::pio_word_t wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output pio_pkg::pio_resp_t bresp,
  output logic bvalid,
  input wire logic bready,
  input wire pio_pkg::pio_addr_t araddr,
  input wire logic arvalid,
  output logic arready,
  output pio_pkg::pio_word_t rdata,
  output pio_pkg::pio_resp_t rresp,
  output logic rvalid,
  input wire logic rready,
  pio_regbus_if.bus regs
);
  import pio_pkg::*;

  logic aw_full;
  logic w_full;
  logic rd_pend;
  pio_addr_t aw_addr;
  pio_byte_t w_data;
  logic w_lane;
  pio_addr_t ar_addr;

  ////////////////////////////////////////////////////////////////////////////
  // Write address and data capture, either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
    end
    else
    begin
      if (awvalid && awready)
        aw_full <= 1'b1;
      else if (regs.wr_req)
        aw_full <= 1'b0;
      if (wvalid && wready)
        w_full <= 1'b1;
      else if (regs.wr_req)
        w_full <= 1'b0;
      awready <= !aw_full && !(awvalid && awready) && !bvalid;
      wready <= !w_full && !(wvalid && wready) && !bvalid;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (awvalid && awready)
      aw_addr <= awaddr;
    if (wvalid && wready)
    begin
      w_data <= wdata[7:0];
      w_lane <= wstrb[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp <= `PIO_RESP_OKAY;
    end
    else if (regs.wr_req)
    begin
      bvalid <= 1'b1;
      bresp <= regs.wr_ok ? `PIO_RESP_OKAY : `PIO_RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rd_pend <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `PIO_RESP_OKAY;
    end
    else
    begin
      arready <= !rd_pend && !rvalid && !(arvalid && arready);
      rd_pend <= arvalid && arready;
      if (rd_pend)
      begin
        rvalid <= 1'b1;
        rdata <= {24'h00_0000, regs.rd_data};
        rresp <= regs.rd_ok ? `PIO_RESP_OKAY : `PIO_RESP_SLVERR;
      end
      else if (rready)
        rvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (arvalid && arready)
      ar_addr <= araddr;
  end

  assign regs.wr_req = aw_full && w_full && !bvalid;
  assign regs.wr_addr = aw_addr;
  assign regs.wr_data = w_data;
  assign regs.wr_lane = w_lane;
  assign regs.rd_req = rd_pend;
  assign regs.rd_addr = ar_addr;
endmodule

// ==== verilog/pio_port_top.sv ====
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ns
`include "pio_map.svh"
// Summary of operation
// (R1) Thirteen bidirectional pins, each with direction bit
// (R2) Pull-up only in input mode when selected
// (R3) Pull-ups grouped: four, four, one, three, one
// (R4) Low four port-one pins select high drive
// (R5) Port four bit two is input only
// (R6) Port four bits six, seven input without oscillator
// (R7) Direction registers clear; data latches undefined
// (R8) Pull-up A 00XX0000b; drive, mode clear
// (R9) Mode bit picks serial unit personality
// (R10) Software avoids reserved addresses
// (R11) Read pin in input, latch in output
// (R12) Unimplemented direction and data bits read zero
// (R13) Mode bit three pin choice, bit seven personality
// (R14) Byte registers, single-cycle, captured on strobe
module pio_port_top
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire pio_pkg::pio_addr_t s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire pio_pkg::pio_word_t s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output pio_pkg::pio_resp_t s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire pio_pkg::pio_addr_t s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output pio_pkg::pio_word_t s_axi_rdata,
  output pio_pkg::pio_resp_t s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire pio_pkg::pio_byte_t port_one_pin_in,
  output pio_pkg::pio_byte_t port_one_pin_out,
  output pio_pkg::pio_byte_t port_one_pin_oe,
  output pio_pkg::pio_byte_t port_one_pullup,
  output logic [3:0] port_one_high_drive,
  input wire pio_pkg::pio_byte_t port_three_pin_in,
  output pio_pkg::pio_byte_t port_three_pin_out,
  output pio_pkg::pio_byte_t port_three_pin_oe,
  output pio_pkg::pio_byte_t port_three_pullup,
  input wire pio_pkg::pio_byte_t port_four_pin_in,
  output pio_pkg::pio_byte_t port_four_pin_out,
  output pio_pkg::pio_byte_t port_four_pin_oe,
  output pio_pkg::pio_byte_t port_four_pullup,
  input wire logic main_osc_in_use,
  output pio_pkg::pio_personality_t serial_unit_personality_select,
  output logic serial_select_pin_choice
);
  import pio_pkg::*;

  pio_regbus_if bus_if ();

  pio_byte_t port_one_latch;
  pio_byte_t port_three_latch;
  pio_byte_t port_four_latch;
  pio_byte_t port_one_direction;
  pio_byte_t port_three_direction;
  pio_byte_t port_four_direction;
  pio_byte_t pin_function_mode;
  logic [1:0] pullup_port_one_sel;
  logic [1:0] pullup_port_three_sel;
  logic pullup_port_four_sel;
  logic [3:0] drive_strength_control;
  pio_index_t wr_index;
  pio_index_t rd_index;
  logic wr_take;
  pio_byte_t pullup_control_a;
  pio_byte_t pullup_control_b;
  pio_byte_t port_four_input_mask;
  pio_byte_t next_port_one_pullup;
  pio_byte_t next_port_three_pullup;
  pio_byte_t next_port_four_pullup;
  pio_byte_t rd_value;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode helpers
  function automatic pio_index_t reg_index(input pio_addr_t addr);
    reg_index = addr[11:2];
  endfunction

  function automatic logic is_mapped(input pio_addr_t addr);
    pio_index_t idx;
    idx = reg_index(addr);
    is_mapped = 1'b0;
    if (addr[1:0] == 2'h0)
    begin
      case (idx)
        `PIO_IDX_PORT_ONE_DATA,
        `PIO_IDX_PORT_ONE_DIR,
        `PIO_IDX_PORT_THREE_DATA,
        `PIO_IDX_PORT_THREE_DIR,
        `PIO_IDX_PORT_FOUR_DATA,
        `PIO_IDX_PORT_FOUR_DIR,
        `PIO_IDX_PIN_MODE,
        `PIO_IDX_PULLUP_A,
        `PIO_IDX_PULLUP_B,
        `PIO_IDX_DRIVE:
          is_mapped = 1'b1;
        default:
          is_mapped = 1'b0;
      endcase
    end
  endfunction

  // Mixes pin level and latch per direction bit
  function automatic pio_byte_t port_read(input pio_byte_t pins,
                                          input pio_byte_t latch,
                                          input pio_byte_t dir,
                                          input pio_byte_t mask);
    port_read = ((dir & latch) | (~dir & pins)) & mask;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave
  pio_axil_slave u_slave
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .regs(bus_if.bus)
  );

  // (R10) Reserved addresses answer with an error
  assign bus_if.wr_ok = is_mapped(bus_if.wr_addr);
  assign bus_if.rd_ok = is_mapped(bus_if.rd_addr);
  assign wr_index = reg_index(bus_if.wr_addr);
  assign rd_index = reg_index(bus_if.rd_addr);
  // (R14) Write captured on the strobe
  assign wr_take = bus_if.wr_req && bus_if.wr_ok && bus_if.wr_lane;

  ////////////////////////////////////////////////////////////////////////////
  // Data latches, left undefined by reset
  // (R7) Latches have no reset
  always_ff @(posedge aclk)
  begin
    if (wr_take)
    begin
      case (wr_index)
        `PIO_IDX_PORT_ONE_DATA:
          port_one_latch <= bus_if.wr_data & `PIO_MASK_PORT_ONE;
        `PIO_IDX_PORT_THREE_DATA:
          port_three_latch <= bus_if.wr_data & `PIO_MASK_PORT_THREE;
        `PIO_IDX_PORT_FOUR_DATA:
          port_four_latch <= bus_if.wr_data & `PIO_MASK_PORT_FOUR_DIR;
        default:
          ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Direction registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // (R7) All pins to input
      port_one_direction <= `PIO_RST_DIR;
      port_three_direction <= `PIO_RST_DIR;
      port_four_direction <= `PIO_RST_DIR;
    end
    else if (wr_take)
    begin
      // (R1) Per-pin direction bits
      case (wr_index)
        `PIO_IDX_PORT_ONE_DIR:
          port_one_direction <= bus_if.wr_data & `PIO_MASK_PORT_ONE;
        `PIO_IDX_PORT_THREE_DIR:
          port_three_direction <= bus_if.wr_data & `PIO_MASK_PORT_THREE;
        `PIO_IDX_PORT_FOUR_DIR:
          port_four_direction <= bus_if.wr_data & `PIO_MASK_PORT_FOUR_DIR;
        default:
          ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode and drive registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // (R8) Mode and drive clear
      pin_function_mode <= `PIO_RST_PIN_MODE;
      drive_strength_control <= `PIO_RST_DRIVE;
    end
    else if (wr_take)
    begin
      case (wr_index)
        // (R13) Only pin choice and personality stored
        `PIO_IDX_PIN_MODE:
          pin_function_mode <= bus_if.wr_data & `PIO_MASK_PIN_MODE;
        `PIO_IDX_DRIVE:
          drive_strength_control <= bus_if.wr_data[3:0];
        default:
          ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pull-up select registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // (R8) Pull-up A low group bits clear
      pullup_port_one_sel <= `PIO_RST_PU_ONE;
      pullup_port_four_sel <= `PIO_RST_PU_FOUR;
    end
    else if (wr_take)
    begin
      case (wr_index)
        `PIO_IDX_PULLUP_A:
          pullup_port_one_sel <= bus_if.wr_data[`PIO_BIT_PU_ONE_HIGH:
                                                `PIO_BIT_PU_ONE_LOW];
        `PIO_IDX_PULLUP_B:
          pullup_port_four_sel <= bus_if.wr_data[`PIO_BIT_PU_FOUR];
        default:
          ;
      endcase
    end
  end

  // (R8) Undefined bits keep their value through reset
  always_ff @(posedge aclk)
  begin
    if (wr_take && wr_index == `PIO_IDX_PULLUP_A)
      pullup_port_three_sel <= bus_if.wr_data[`PIO_BIT_PU_THREE_HIGH:
                                              `PIO_BIT_PU_THREE_LOW];
  end

  always_comb
  begin
    pullup_control_a = 8'h00;
    pullup_control_a[`PIO_BIT_PU_ONE_HIGH:`PIO_BIT_PU_ONE_LOW] =
      pullup_port_one_sel;
    pullup_control_a[`PIO_BIT_PU_THREE_HIGH:`PIO_BIT_PU_THREE_LOW] =
      pullup_port_three_sel;
    pullup_control_b = 8'h00;
    pullup_control_b[`PIO_BIT_PU_FOUR] = pullup_port_four_sel;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Readback
  always_comb
  begin
    // (R6) Oscillator pins read only when free
    port_four_input_mask = `PIO_MASK_PORT_FOUR_IN;
    if (!main_osc_in_use)
      port_four_input_mask = port_four_input_mask | `PIO_MASK_PORT_FOUR_OSC;
  end

  always_comb
  begin
    rd_value = 8'h00;
    case (rd_index)
      // (R11) Pin level or latch per bit
      `PIO_IDX_PORT_ONE_DATA:
        rd_value = port_read(port_one_pin_in, port_one_latch,
                             port_one_direction, `PIO_MASK_PORT_ONE);
      // (R12) Missing pins read zero
      `PIO_IDX_PORT_THREE_DATA:
        rd_value = port_read(port_three_pin_in, port_three_latch,
                             port_three_direction, `PIO_MASK_PORT_THREE);
      // (R5) Input-only bit two always pin level
      `PIO_IDX_PORT_FOUR_DATA:
        rd_value = port_read(port_four_pin_in, port_four_latch,
                             port_four_direction, `PIO_MASK_PORT_FOUR_DIR)
                   | (port_four_pin_in & port_four_input_mask);
      `PIO_IDX_PORT_ONE_DIR:
        rd_value = port_one_direction;
      `PIO_IDX_PORT_THREE_DIR:
        rd_value = port_three_direction;
      `PIO_IDX_PORT_FOUR_DIR:
        rd_value = port_four_direction;
      `PIO_IDX_PIN_MODE:
        rd_value = pin_function_mode;
      `PIO_IDX_PULLUP_A:
        rd_value = pullup_control_a;
      `PIO_IDX_PULLUP_B:
        rd_value = pullup_control_b;
      `PIO_IDX_DRIVE:
        rd_value = {4'h0, drive_strength_control};
      default:
        rd_value = 8'h00;
    endcase
  end

  assign bus_if.rd_data = bus_if.rd_ok ? rd_value : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port_one_pin_out <= 8'h00;
      port_one_pin_oe <= 8'h00;
      port_three_pin_out <= 8'h00;
      port_three_pin_oe <= 8'h00;
      port_four_pin_out <= 8'h00;
      port_four_pin_oe <= 8'h00;
    end
    else
    begin
      // (R11) Latch drives pin only in output mode
      port_one_pin_out <= port_one_latch & port_one_direction;
      port_one_pin_oe <= port_one_direction;
      port_three_pin_out <= port_three_latch & port_three_direction;
      port_three_pin_oe <= port_three_direction;
      // (R5) No driver on input-only pins
      port_four_pin_out <= port_four_latch & port_four_direction;
      port_four_pin_oe <= port_four_direction & `PIO_MASK_PORT_FOUR_DIR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pull-up enables
  always_comb
  begin
    // (R3) Group select fan-out
    next_port_one_pullup = {{4{pullup_port_one_sel[1]}},
                            {4{pullup_port_one_sel[0]}}};
    next_port_three_pullup = {pullup_port_three_sel[1], 1'b0,
                              {2{pullup_port_three_sel[1]}},
                              pullup_port_three_sel[0], 3'h0};
    next_port_four_pullup = {2'h0, pullup_port_four_sel, 5'h00};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port_one_pullup <= 8'h00;
      port_three_pullup <= 8'h00;
      port_four_pullup <= 8'h00;
    end
    else
    begin
      // (R2) Pull-up only on input pins
      port_one_pullup <= next_port_one_pullup & ~port_one_direction;
      port_three_pullup <= next_port_three_pullup & ~port_three_direction;
      port_four_pullup <= next_port_four_pullup & ~port_four_direction;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Drive strength and serial unit steering
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port_one_high_drive <= 4'h0;
      serial_unit_personality_select <= PIO_SERIAL_CLOCKED;
      serial_select_pin_choice <= 1'b0;
    end
    else
    begin
      // (R4) High drive on low four pins
      port_one_high_drive <= drive_strength_control;
      // (R9) Personality from mode register
      serial_unit_personality_select <=
        pin_function_mode[`PIO_BIT_PERSONALITY] ? PIO_SERIAL_TWO_WIRE
                                                 : PIO_SERIAL_CLOCKED;
      // (R13) Select-input pin choice
      serial_select_pin_choice <= pin_function_mode[`PIO_BIT_SSI_CHOICE];
    end
  end
endmodule
